/* File: scer_cdr_eq_config_regs.sv */
// Recovery mode, recovery reset and equalizer boost registers behind the configuration port.
//
// Function
// - Half-rate enable resets to one; one means half-rate recovery above 6 Gbps.
// - Two-bit divider resets to 00; 00 none, 01 by two, 10 by four.
// - Boost code 0000 puts its PHY into manual equalizer mode.
// - Nonzero boost code is the boost level; low nibble first PHY; both reset 8.
// - Recovery reset resets to one and holds the clock recovery logic while set; equalizer outputs are not held.
`timescale 1ns/100ps
`default_nettype none
module scer_cdr_eq_config_regs (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire scer_pkg::scer_req_s req,
    output var  logic [7:0]        rdata,
    output var  logic              rvalid,
    output var  logic              recovery_half_rate_enable,
    output var  scer_pkg::scer_div_e oversample_divider,
    output var  logic              divider_unsupported,
    output var  logic              recovery_logic_reset,
    output var  scer_pkg::scer_eq_s equalizer_boost_first_phy,
    output var  scer_pkg::scer_eq_s equalizer_boost_second_phy
);

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [7:0] mode_reg;
    logic [7:0] mode_next;
    logic [7:0] boost_reg;
    logic [7:0] boost_next;
    logic [7:0] rst_reg;
    logic [7:0] rst_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic       rvalid_reg;
    logic       rvalid_next;
    logic       half_reg;
    logic       half_next;
    logic [1:0] div_reg;
    logic [1:0] div_next;
    logic       unsup_reg;
    logic       unsup_next;
    logic       prst_reg;
    logic       prst_next;

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    // Writes land in storage at the taking edge; outputs follow one edge later.
    always_comb begin
        mode_next  = mode_reg;
        boost_next = boost_reg;
        rst_next   = rst_reg;
        if (req.write) begin
            unique case (req.addr)
                scer_pkg::CLOCK_RECOVERY_MODE_ADDR: begin
                    mode_next = req.wdata;
                end
                scer_pkg::EQUALIZER_BOOST_LANES_0_1_ADDR: begin
                    boost_next = req.wdata;
                end
                scer_pkg::RECOVERY_RESET_ADDR: begin
                    rst_next = req.wdata & scer_pkg::RECOVERY_RESET_WMASK;
                end
                default: begin
                    mode_next = mode_reg;
                end
            endcase
        end
        rvalid_next = req.read;
        rdata_next  = 8'h00;
        if (req.read) begin
            unique case (req.addr)
                scer_pkg::CLOCK_RECOVERY_MODE_ADDR: begin
                    rdata_next = mode_reg;
                end
                scer_pkg::EQUALIZER_BOOST_LANES_0_1_ADDR: begin
                    rdata_next = boost_reg;
                end
                scer_pkg::RECOVERY_RESET_ADDR: begin
                    rdata_next = rst_reg;
                end
                default: begin
                    rdata_next = 8'h00;
                end
            endcase
        end
        half_next  = mode_reg[scer_pkg::HALF_RATE_BIT];
        div_next   = mode_reg[scer_pkg::DIVIDER_LSB +: 2];
        unsup_next = (mode_reg[scer_pkg::DIVIDER_LSB +: 2] == 2'h3);
        prst_next  = rst_reg[scer_pkg::RESET_BIT];
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode_reg   <= scer_pkg::CLOCK_RECOVERY_MODE_RST;
            boost_reg  <= scer_pkg::EQUALIZER_BOOST_LANES_0_1_RST;
            rst_reg    <= scer_pkg::RECOVERY_RESET_RST;
            rdata_reg  <= 8'h00;
            rvalid_reg <= 1'b0;
            half_reg   <= scer_pkg::CLOCK_RECOVERY_MODE_RST[scer_pkg::HALF_RATE_BIT];
            div_reg    <= scer_pkg::CLOCK_RECOVERY_MODE_RST[scer_pkg::DIVIDER_LSB +: 2];
            unsup_reg  <= 1'b0;
            prst_reg   <= scer_pkg::RECOVERY_RESET_RST[scer_pkg::RESET_BIT];
        end else begin
            mode_reg   <= mode_next;
            boost_reg  <= boost_next;
            rst_reg    <= rst_next;
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
            half_reg   <= half_next;
            div_reg    <= div_next;
            unsup_reg  <= unsup_next;
            prst_reg   <= prst_next;
        end
    end

    // ------------------------------------------------------------------
    // Equalizer decode per PHY
    // ------------------------------------------------------------------
    scer_pkg::scer_eq_s eq_out [2];

    for (genvar i = 0; i < 2; i++) begin : g_eq
        scer_eq_decode u_dec (
            .clk  (clk),
            .rstn (rstn),
            .code (boost_reg[i*4 +: 4]),
            .eq   (eq_out[i])
        );
    end

    assign rdata                      = rdata_reg;
    assign rvalid                     = rvalid_reg;
    assign recovery_half_rate_enable  = half_reg;
    assign oversample_divider         = scer_pkg::scer_div_e'(div_reg);
    assign divider_unsupported        = unsup_reg;
    assign recovery_logic_reset       = prst_reg;
    assign equalizer_boost_first_phy  = eq_out[0];
    assign equalizer_boost_second_phy = eq_out[1];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Each configuration output follows a write two edges later: storage, then output flop.
    sequence mode_write_s;
        req.write && req.addr == scer_pkg::CLOCK_RECOVERY_MODE_ADDR;
    endsequence

    sequence boost_write_s;
        req.write && req.addr == scer_pkg::EQUALIZER_BOOST_LANES_0_1_ADDR;
    endsequence

    sequence reset_write_s;
        req.write && req.addr == scer_pkg::RECOVERY_RESET_ADDR;
    endsequence

    half_rate_a: assert property (@(posedge clk) disable iff (!rstn)
        mode_write_s |-> ##2 half_reg == $past(req.wdata[5], 2))
        else $error("half rate output does not follow write");

    half_reset_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(rstn) |-> half_reg == 1'b1)
        else $error("half rate output not set after reset");

    divider_a: assert property (@(posedge clk) disable iff (!rstn)
        mode_write_s |-> ##2 div_reg == $past(req.wdata[2:1], 2))
        else $error("divider output does not follow write");

    divider_reset_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(rstn) |-> div_reg == 2'h0)
        else $error("divider output not cleared after reset");

    unsup_a: assert property (@(posedge clk) disable iff (!rstn)
        mode_write_s |-> ##2 unsup_reg == ($past(req.wdata[2:1], 2) == 2'h3))
        else $error("unsupported flag wrong");

    reserved_a: assert property (@(posedge clk) disable iff (!rstn)
        mode_write_s |=> mode_reg == $past(req.wdata))
        else $error("mode register lost written bits");

    reserved_reset_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(rstn) |-> mode_reg[7:6] == 2'h0 && mode_reg[4:3] == 2'h1 && mode_reg[0] == 1'b0)
        else $error("reserved mode bits wrong after reset");

    reset_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        rst_reg[0] |=> prst_reg)
        else $error("recovery reset not asserted");

    reset_write_a: assert property (@(posedge clk) disable iff (!rstn)
        reset_write_s |-> ##2 prst_reg == $past(req.wdata[0], 2))
        else $error("recovery reset output does not follow write");

    reset_mask_a: assert property (@(posedge clk) disable iff (!rstn)
        reset_write_s |=> rst_reg == {7'h00, $past(req.wdata[0])})
        else $error("recovery reset register upper bits not zero");

    recovery_reset_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(rstn) |-> prst_reg == 1'b1)
        else $error("recovery reset not held after reset");

    boost_first_a: assert property (@(posedge clk) disable iff (!rstn)
        boost_write_s
        |-> ##2 equalizer_boost_first_phy.boost_level == $past(req.wdata[3:0], 2))
        else $error("first PHY boost wrong");

    boost_second_a: assert property (@(posedge clk) disable iff (!rstn)
        boost_write_s
        |-> ##2 equalizer_boost_second_phy.boost_level == $past(req.wdata[7:4], 2))
        else $error("second PHY boost wrong");

    boost_reset_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(rstn) |-> boost_reg == 8'h88)
        else $error("boost register wrong after reset");

    manual_a: assert property (@(posedge clk) disable iff (!rstn)
        boost_reg[3:0] == 4'h0 ##1 boost_reg[3:0] == 4'h0
        |-> equalizer_boost_first_phy.manual_mode)
        else $error("manual mode missing");

    manual_second_a: assert property (@(posedge clk) disable iff (!rstn)
        boost_reg[7:4] == 4'h0 ##1 boost_reg[7:4] == 4'h0
        |-> equalizer_boost_second_phy.manual_mode)
        else $error("second PHY manual mode missing");

endmodule
`default_nettype wire

/* File: scer_eq_decode.sv */
// Decoder from one equalizer boost code to manual mode or a boost level.
`timescale 1ns/100ps
`default_nettype none
module scer_eq_decode (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [3:0] code,
    output var  scer_pkg::scer_eq_s eq
);
    scer_pkg::scer_eq_s eq_reg;
    scer_pkg::scer_eq_s eq_next;

    always_comb begin
        eq_next.manual_mode = (code == scer_pkg::BOOST_MANUAL_CODE);
        eq_next.boost_level = code;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            eq_reg <= '{manual_mode: 1'b0,
                        boost_level: scer_pkg::EQUALIZER_BOOST_LANES_0_1_RST[scer_pkg::BOOST0_LSB +: 4]};
        end else begin
            eq_reg <= eq_next;
        end
    end

    assign eq = eq_reg;

    manual_follow_a: assert property (@(posedge clk) disable iff (!rstn)
        eq_reg.manual_mode == ($past(code) == 4'h0))
        else $error("manual mode does not match code zero");

    level_follow_a: assert property (@(posedge clk) disable iff (!rstn)
        $past(code) != 4'h0 |-> eq_reg.boost_level == $past(code))
        else $error("boost level differs from code");
endmodule
`default_nettype wire

/* File: scer_pkg.sv */
// Package with register map, field layout and shared types for the recovery configuration block.
package scer_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] CLOCK_RECOVERY_MODE_ADDR       = 12'h230;
    localparam logic [11:0] EQUALIZER_BOOST_LANES_0_1_ADDR = 12'h250;
    localparam logic [11:0] RECOVERY_RESET_ADDR            = 12'h206;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int HALF_RATE_BIT  = 5;
    localparam int DIVIDER_LSB    = 1;
    localparam int BOOST0_LSB     = 0;
    localparam int BOOST1_LSB     = 4;
    localparam int RESET_BIT      = 0;

    // ------------------------------------------------------------------
    // Reset values and recovery reset write mask
    // ------------------------------------------------------------------
    localparam logic [7:0] CLOCK_RECOVERY_MODE_RST       = 8'h28;
    localparam logic [7:0] EQUALIZER_BOOST_LANES_0_1_RST = 8'h88;
    localparam logic [7:0] RECOVERY_RESET_RST            = 8'h01;
    localparam logic [7:0] RECOVERY_RESET_WMASK          = 8'h01;

    // ------------------------------------------------------------------
    // Encodings and shared types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SCER_DIV_NONE = 2'h0,
        SCER_DIV_TWO  = 2'h1,
        SCER_DIV_FOUR = 2'h2,
        SCER_DIV_RSVD = 2'h3
    } scer_div_e;

    localparam logic [3:0] BOOST_MANUAL_CODE = 4'h0;

    typedef struct packed {
        logic       write;
        logic       read;
        logic [11:0] addr;
        logic [7:0] wdata;
    } scer_req_s;

    typedef struct packed {
        logic       manual_mode;
        logic [3:0] boost_level;
    } scer_eq_s;

endpackage

/* File: serdes_cdr_eq_config_regs_bench.sv */
// Self-checking bench for the recovery mode, recovery reset and equalizer boost registers.
`timescale 1ns/100ps
`default_nettype none
module serdes_cdr_eq_config_regs_bench;
    logic                clk;
    logic                rstn;
    scer_pkg::scer_req_s req;
    logic [7:0]          rdata;
    logic                rvalid;
    logic                half_rate;
    scer_pkg::scer_div_e divider;
    logic                div_bad;
    logic                cdr_rst;
    scer_pkg::scer_eq_s  eq0;
    scer_pkg::scer_eq_s  eq1;
    int                  error_cnt;
    int                  samples_checked;

    scer_cdr_eq_config_regs u_dut (
        .clk                        (clk),
        .rstn                       (rstn),
        .req                        (req),
        .rdata                      (rdata),
        .rvalid                     (rvalid),
        .recovery_half_rate_enable  (half_rate),
        .oversample_divider         (divider),
        .divider_unsupported        (div_bad),
        .recovery_logic_reset       (cdr_rst),
        .equalizer_boost_first_phy  (eq0),
        .equalizer_boost_second_phy (eq1)
    );

    initial clk = 1'b0;
    always #10 clk = ~clk;

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    // Every task is entered one nanosecond after a rising edge and leaves the same way.
    task automatic check(input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: expected %h got %h", $time, exp, got);
        end
    endtask

    task automatic wr(input logic [11:0] addr, input logic [7:0] data);
        req.addr = addr;
        req.wdata = data;
        req.write = 1'b1;
        @(posedge clk);
        #1 req.write = 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic rd_check(input logic [11:0] addr, input logic [7:0] exp);
        req.addr = addr;
        req.read = 1'b1;
        @(posedge clk);
        #1 req.read = 1'b0;
        check(8'h01, {7'h0, rvalid});
        check(exp, rdata);
        @(posedge clk);
        #1;
    endtask

    task automatic summarize();
        $display("checked %0d, errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_reset();
        check(8'h01, {7'h0, half_rate});
        check(8'h00, {6'h0, divider});
        check(8'h08, {3'h0, eq0});
        check(8'h08, {3'h0, eq1});
        check(8'h01, {7'h0, cdr_rst});
        rd_check(12'h230, 8'h28);
        rd_check(12'h250, 8'h88);
        rd_check(12'h206, 8'h01);
        $display("test_reset done, errors %0d", error_cnt);
    endtask

    // Steps half rate and every divider code, reserved bits kept at reset values.
    task automatic test_mode();
        logic [7:0] v;
        for (int i = 0; i < 8; i++) begin
            v = {2'h0, i[2], 2'h1, i[1:0], 1'b0};
            wr(12'h230, v);
            check({7'h0, v[5]}, {7'h0, half_rate});
            check({6'h0, v[2:1]}, {6'h0, divider});
            check({7'h0, v[2:1] == 2'h3}, {7'h0, div_bad});
            rd_check(12'h230, v);
        end
        $display("test_mode done, errors %0d", error_cnt);
    endtask

    // Every boost code on the first PHY, the inverse code on the second.
    task automatic test_boost();
        logic [3:0] c;
        for (int i = 0; i < 16; i++) begin
            c = i[3:0];
            wr(12'h250, {~c, c});
            check({7'h0, c == 4'h0}, {7'h0, eq0.manual_mode});
            check({7'h0, c == 4'hf}, {7'h0, eq1.manual_mode});
            if (c != 4'h0) check({4'h0, c}, {4'h0, eq0.boost_level});
            if (c != 4'hf) check({4'h0, ~c}, {4'h0, eq1.boost_level});
            rd_check(12'h250, {~c, c});
        end
        $display("test_boost done, errors %0d", error_cnt);
    endtask

    // Recovery reset bit, forced-zero upper bits and an unmapped address.
    task automatic test_cdr();
        wr(12'h206, 8'hfe);
        check(8'h00, {7'h0, cdr_rst});
        rd_check(12'h206, 8'h00);
        wr(12'h206, 8'hff);
        check(8'h01, {7'h0, cdr_rst});
        rd_check(12'h206, 8'h01);
        wr(12'h231, 8'h55);
        rd_check(12'h231, 8'h00);
        rd_check(12'h230, 8'h2e);
        check(8'h01, {7'h0, half_rate});
        $display("test_cdr done, errors %0d", error_cnt);
    endtask

    // Non-default values everywhere, then a reset in mid-run must restore every reset value.
    task automatic test_rerun();
        wr(12'h230, 8'h0c);
        wr(12'h250, 8'h30);
        wr(12'h206, 8'h00);
        check(8'h00, {7'h0, half_rate});
        check(8'h02, {6'h0, divider});
        check(8'h10, {3'h0, eq0});
        check(8'h03, {3'h0, eq1});
        check(8'h00, {7'h0, cdr_rst});
        rstn = 1'b0;
        repeat (3) @(posedge clk);
        #1 rstn = 1'b1;
        test_reset();
        $display("test_rerun done, errors %0d", error_cnt);
    endtask

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        req = '0;
        rstn = 1'b0;
        error_cnt = 0;
        samples_checked = 0;
        repeat (20) @(posedge clk);
        #1 rstn = 1'b1;
        test_reset();
        test_mode();
        test_boost();
        test_cdr();
        test_rerun();
        summarize();
    end

    // The tests need about 180 cycles; the limit allows far more.
    initial begin
        #100000;
        error_cnt++;
        summarize();
    end
endmodule
`default_nettype wire
